// ### hdl/kip_slave_port.sv
// two-wire serial slave port with pointer, write buffer and bus timeout
//
// Overview of operation
// - ninth clock carries the receiver's low acknowledge
// - device acknowledges its own address and the command byte, data bytes while the write buffer has room
// - 7-bit address then direction bit, 1 reads
// - upper four address bits are 0111
// - low address bits follow strap pin connection
// - watch for start plus own address, acknowledge
// - clock low past 20 ms aborts, releases data
// - after timeout, wait for a fresh start
// - timeout detection switched by configuration bit
// - first written byte is the command pointer
// - stop after command only stores the pointer
// - data bytes go where the pointer points
// - pointer holds at 0x00, wraps 0x06 to 0x00
// - pointer steps at 0x01-0x05 and 0x40-0x5f
// - reads start at stored pointer, same stepping
// - pointer steps only after data bytes
// - start and stop are data edges, clock high
// - data stable while clock high, one bit per pulse
// - timeout sets flag, raises interrupt, read clears
`include "kip_params.svh"
`timescale 1ns/1ps
`default_nettype none

module kip_slave_port #(
  parameter int TOUT_MS = `KIP_TOUT_MS,
  parameter int CLK_KHZ = `KIP_CLK_KHZ,
  parameter int TOUT_CYCLES = TOUT_MS * CLK_KHZ,
  parameter int FIFO_DEPTH = `KIP_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic address_strap_pin,
  input wire logic timeoutEn,
  input wire logic flagRdClr,
  output logic timeoutFlag,
  output logic port_event_irq_n,
  output logic [7:0] rdAddr,
  input wire logic [7:0] rdData,
  output logic rdStrobe,
  output logic wrValid,
  input wire logic wrReady,
  output kip_pkg::kip_wr_s wrData
);

  localparam int CW = $clog2(TOUT_CYCLES + 1);
  localparam int WW = $bits(kip_pkg::kip_wr_s);

  typedef struct packed {
    kip_pkg::kip_pins_s pins;
    kip_pkg::kip_strap_s strap;
    kip_pkg::kip_state_e state;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic rw;
    logic [7:0] ptr;
    logic oe;
    logic [CW-1:0] toutCnt;
    logic toutFlag;
    logic rdStrobe;
  } kip_port_state_s;

  kip_port_state_s cur_ff;
  kip_port_state_s nxt_port;

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic [2:0] addrLow;
  logic addrMatch;
  logic pushValid;
  logic pushReady;
  kip_pkg::kip_wr_s pushData;
  logic [WW-1:0] popData;

  // ----------------------------------------------------------------
  // pointer advance
  // ----------------------------------------------------------------
  function automatic logic [7:0] incPtr(input logic [7:0] p);
    logic [7:0] r;
    r = p;
    if (p == `KIP_PTR_HOLD)
    begin
      r = `KIP_PTR_HOLD;
    end
    else if (p == `KIP_PTR_WRAP)
    begin
      r = `KIP_PTR_HOLD;
    end
    else if ((p >= `KIP_PTR_KEY_LO && p <= `KIP_PTR_KEY_HI) ||
             (p >= `KIP_PTR_GPIO_LO && p <= `KIP_PTR_GPIO_HI))
    begin
      r = p + `KIP_PTR_STEP;
    end
    return r;
  endfunction : incPtr

  // ----------------------------------------------------------------
  // bus conditions
  // ----------------------------------------------------------------
  assign sclRise = cur_ff.pins.sclSync && !cur_ff.pins.sclPrev;
  assign sclFall = !cur_ff.pins.sclSync && cur_ff.pins.sclPrev;
  // data edges with the clock high on both samples
  assign startCond = cur_ff.pins.sclSync && cur_ff.pins.sclPrev &&
                     cur_ff.pins.sdaPrev && !cur_ff.pins.sdaSync;
  assign stopCond = cur_ff.pins.sclSync && cur_ff.pins.sclPrev &&
                    !cur_ff.pins.sdaPrev && cur_ff.pins.sdaSync;

  // ----------------------------------------------------------------
  // own address from the strap connection
  // ----------------------------------------------------------------
  always_comb
  begin
    if (!cur_ff.strap.seenLo)
    begin
      addrLow = `KIP_LOW_VCC;
    end
    else if (!cur_ff.strap.seenHi)
    begin
      addrLow = `KIP_LOW_GND;
    end
    // a strap on the data line matches it but differs from the clock after a start
    else if (!cur_ff.strap.diffSda && cur_ff.strap.diffScl)
    begin
      addrLow = `KIP_LOW_SDA;
    end
    else
    begin
      addrLow = `KIP_LOW_SCL;
    end
  end

  assign addrMatch = (cur_ff.shift[7:1] == {`KIP_ADDR_HI, addrLow});

  // ----------------------------------------------------------------
  // write buffer toward the register file
  // ----------------------------------------------------------------
  assign pushValid = sclFall && (cur_ff.state == kip_pkg::ST_WDATA) &&
                     (cur_ff.bitCnt == `KIP_BYTE_BITS);
  assign pushData = '{addr: cur_ff.ptr, data: cur_ff.shift};

  kip_fifo #(
    .WIDTH(WW),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(wrValid),
    .outReady(wrReady),
    .outData(popData)
  );

  assign wrData = popData;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_port = cur_ff;
    nxt_port.rdStrobe = 1'b0;
    nxt_port.pins.sclMeta = scl;
    nxt_port.pins.sclSync = cur_ff.pins.sclMeta;
    nxt_port.pins.sclPrev = cur_ff.pins.sclSync;
    nxt_port.pins.sdaMeta = sdaIn;
    nxt_port.pins.sdaSync = cur_ff.pins.sdaMeta;
    nxt_port.pins.sdaPrev = cur_ff.pins.sdaSync;
    nxt_port.pins.strapMeta = address_strap_pin;
    nxt_port.pins.strapSync = cur_ff.pins.strapMeta;

    // strap watch restarts at every start
    if (startCond)
    begin
      nxt_port.strap.seenLo = !cur_ff.pins.strapSync;
      nxt_port.strap.seenHi = cur_ff.pins.strapSync;
      nxt_port.strap.diffSda = 1'b0;
      nxt_port.strap.diffScl = 1'b0;
    end
    else
    begin
      nxt_port.strap.seenLo = cur_ff.strap.seenLo || !cur_ff.pins.strapSync;
      nxt_port.strap.seenHi = cur_ff.strap.seenHi || cur_ff.pins.strapSync;
      nxt_port.strap.diffSda = cur_ff.strap.diffSda ||
                               (cur_ff.pins.strapSync != cur_ff.pins.sdaSync);
      nxt_port.strap.diffScl = cur_ff.strap.diffScl ||
                               (cur_ff.pins.strapSync != cur_ff.pins.sclSync);
    end

    // timeout flag: read clears, a new timeout in the same cycle wins
    if (flagRdClr)
    begin
      nxt_port.toutFlag = 1'b0;
    end

    if (startCond)
    begin
      // start or repeated start from any state
      nxt_port.state = kip_pkg::ST_ADDR;
      nxt_port.bitCnt = 4'h0;
      nxt_port.oe = 1'b0;
      nxt_port.toutCnt = '0;
    end
    else if (stopCond)
    begin
      // pointer stays as last stored
      nxt_port.state = kip_pkg::ST_IDLE;
      nxt_port.oe = 1'b0;
      nxt_port.toutCnt = '0;
    end
    else if (!timeoutEn || cur_ff.pins.sclSync || cur_ff.state == kip_pkg::ST_IDLE)
    begin
      nxt_port.toutCnt = '0;
    end
    else if (cur_ff.toutCnt == CW'(TOUT_CYCLES - 1))
    begin
      // clock held low too long: drop the transfer, wait for a start
      nxt_port.state = kip_pkg::ST_IDLE;
      nxt_port.oe = 1'b0;
      nxt_port.toutCnt = '0;
      nxt_port.toutFlag = 1'b1;
    end
    else
    begin
      nxt_port.toutCnt = cur_ff.toutCnt + {{(CW-1){1'b0}}, 1'b1};
    end

    if (!startCond && !stopCond && nxt_port.state == cur_ff.state)
    begin
      unique case (cur_ff.state)
        kip_pkg::ST_IDLE:
        begin
          nxt_port.oe = 1'b0;
        end
        kip_pkg::ST_ADDR, kip_pkg::ST_CMD, kip_pkg::ST_WDATA:
        begin
          if (sclRise && cur_ff.bitCnt != `KIP_BYTE_BITS)
          begin
            // one bit per clock pulse, taken while the clock is high
            nxt_port.shift = {cur_ff.shift[6:0], cur_ff.pins.sdaSync};
            nxt_port.bitCnt = cur_ff.bitCnt + 4'h1;
          end
          else if (sclFall && cur_ff.bitCnt == `KIP_BYTE_BITS)
          begin
            if (cur_ff.state == kip_pkg::ST_ADDR)
            begin
              if (addrMatch)
              begin
                nxt_port.rw = cur_ff.shift[0];
                nxt_port.oe = 1'b1;
                nxt_port.state = kip_pkg::ST_ADDR_ACK;
              end
              else
              begin
                nxt_port.state = kip_pkg::ST_IDLE;
              end
            end
            else if (cur_ff.state == kip_pkg::ST_CMD)
            begin
              nxt_port.ptr = cur_ff.shift;
              nxt_port.oe = 1'b1;
              nxt_port.state = kip_pkg::ST_CMD_ACK;
            end
            else if (pushReady)
            begin
              nxt_port.ptr = incPtr(cur_ff.ptr);
              nxt_port.oe = 1'b1;
              nxt_port.state = kip_pkg::ST_WDATA_ACK;
            end
            else
            begin
              // buffer full: byte refused without acknowledge
              nxt_port.state = kip_pkg::ST_IDLE;
            end
          end
        end
        kip_pkg::ST_ADDR_ACK:
        begin
          if (sclFall)
          begin
            nxt_port.bitCnt = 4'h0;
            if (cur_ff.rw)
            begin
              nxt_port.shift = rdData;
              nxt_port.rdStrobe = 1'b1;
              nxt_port.oe = !rdData[7];
              nxt_port.state = kip_pkg::ST_RDATA;
            end
            else
            begin
              nxt_port.oe = 1'b0;
              nxt_port.state = kip_pkg::ST_CMD;
            end
          end
        end
        kip_pkg::ST_CMD_ACK, kip_pkg::ST_WDATA_ACK:
        begin
          if (sclFall)
          begin
            nxt_port.oe = 1'b0;
            nxt_port.bitCnt = 4'h0;
            nxt_port.state = kip_pkg::ST_WDATA;
          end
        end
        kip_pkg::ST_RDATA:
        begin
          if (sclRise)
          begin
            nxt_port.bitCnt = cur_ff.bitCnt + 4'h1;
          end
          else if (sclFall)
          begin
            if (cur_ff.bitCnt == `KIP_BYTE_BITS)
            begin
              // release for the master's acknowledge
              nxt_port.oe = 1'b0;
              nxt_port.ptr = incPtr(cur_ff.ptr);
              nxt_port.state = kip_pkg::ST_RDATA_ACK;
            end
            else
            begin
              nxt_port.shift = {cur_ff.shift[6:0], 1'b0};
              nxt_port.oe = !cur_ff.shift[6];
            end
          end
        end
        kip_pkg::ST_RDATA_ACK:
        begin
          if (sclRise && cur_ff.pins.sdaSync)
          begin
            // no acknowledge: master ends the read
            nxt_port.state = kip_pkg::ST_IDLE;
          end
          else if (sclFall)
          begin
            nxt_port.shift = rdData;
            nxt_port.rdStrobe = 1'b1;
            nxt_port.oe = !rdData[7];
            nxt_port.bitCnt = 4'h0;
            nxt_port.state = kip_pkg::ST_RDATA;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cur_ff <= '0;
      cur_ff.pins.sclMeta <= 1'b1;
      cur_ff.pins.sclSync <= 1'b1;
      cur_ff.pins.sclPrev <= 1'b1;
      cur_ff.pins.sdaMeta <= 1'b1;
      cur_ff.pins.sdaSync <= 1'b1;
      cur_ff.pins.sdaPrev <= 1'b1;
      cur_ff.state <= kip_pkg::ST_IDLE;
    end
    else
    begin
      cur_ff <= nxt_port;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sdaOut = 1'b0;
  assign sdaOe = cur_ff.oe;
  assign timeoutFlag = cur_ff.toutFlag;
  assign port_event_irq_n = !cur_ff.toutFlag;
  assign rdAddr = cur_ff.ptr;
  assign rdStrobe = cur_ff.rdStrobe;

endmodule : kip_slave_port

`default_nettype wire

// ### hdl/kip_params.svh
// constants of the two-wire slave port: address, pointer map, timing, buffer
`ifndef KIP_PARAMS_SVH
`define KIP_PARAMS_SVH

// fixed upper four bits of the 7-bit device address
`define KIP_ADDR_HI 4'h7
// low three address bits per strap connection
`define KIP_LOW_GND 3'h0
`define KIP_LOW_VCC 3'h2
`define KIP_LOW_SDA 3'h4
`define KIP_LOW_SCL 3'h6

// bits in one byte; the acknowledge follows as the ninth
`define KIP_BYTE_BITS 4'h8

// pointer advance map
`define KIP_PTR_HOLD 8'h00
`define KIP_PTR_WRAP 8'h06
`define KIP_PTR_KEY_LO 8'h01
`define KIP_PTR_KEY_HI 8'h05
`define KIP_PTR_GPIO_LO 8'h40
`define KIP_PTR_GPIO_HI 8'h5f
`define KIP_PTR_STEP 8'h01

// bus timeout: least time in ms and system clock rate in kHz
`define KIP_TOUT_MS 20
`define KIP_CLK_KHZ 125000

// depth of the write buffer in words
`define KIP_FIFO_DEPTH 32

`endif

// ### hdl/kip_pkg.sv
// types of the two-wire slave port
`default_nettype none

package kip_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } kip_state_e;

  // one register write: target pointer and data byte
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } kip_wr_s;

  // synchronised pin levels, clock and data with their previous samples
  typedef struct packed {
    logic sclMeta;
    logic sclSync;
    logic sclPrev;
    logic sdaMeta;
    logic sdaSync;
    logic sdaPrev;
    logic strapMeta;
    logic strapSync;
  } kip_pins_s;

  // strap classification gathered since the last start
  typedef struct packed {
    logic seenLo;
    logic seenHi;
    logic diffSda;
    logic diffScl;
  } kip_strap_s;

endpackage : kip_pkg

`default_nettype wire

// ### hdl/kip_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module kip_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } kip_fifo_state_s;

  kip_fifo_state_s cur_ff;
  kip_fifo_state_s nxt_fifo;
  logic full;
  logic empty;

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  assign empty = (cur_ff.wp == cur_ff.rp);
  assign full = (cur_ff.wp[AW] != cur_ff.rp[AW]) && (cur_ff.wp[AW-1:0] == cur_ff.rp[AW-1:0]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = cur_ff.mem[cur_ff.rp[AW-1:0]];

  // ----------------------------------------------------------------
  // pointers and storage
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_fifo = cur_ff;
    if (inValid && !full)
    begin
      nxt_fifo.mem[cur_ff.wp[AW-1:0]] = inData;
      nxt_fifo.wp = cur_ff.wp + {{AW{1'b0}}, 1'b1};
    end
    if (outReady && !empty)
    begin
      nxt_fifo.rp = cur_ff.rp + {{AW{1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_fifo;
    end
  end

endmodule : kip_fifo

`default_nettype wire

// ### hdl/kip_dummy_never.sv
// holds no logic; the port and its buffer live in their own files

// ### bench/kip_slave_port_monitor.sv
// concurrent checks on the slave port pins
`timescale 1ns/1ps
`default_nettype none

module kip_slave_port_monitor #(
  parameter int TOUT_CYCLES = 200
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic address_strap_pin,
  input wire logic timeoutEn,
  input wire logic flagRdClr,
  input wire logic timeoutFlag,
  input wire logic port_event_irq_n,
  input wire logic [7:0] rdAddr,
  input wire logic [7:0] rdData,
  input wire logic rdStrobe,
  input wire logic wrValid,
  input wire logic wrReady,
  input wire kip_pkg::kip_wr_s wrData
);
  // ---
  // helper state
  // ---
  int unsigned lowCnt_ff;
  logic [7:0] strobeAddr_ff;

  function automatic logic [7:0] nextPtr(input logic [7:0] p);
    if ((p >= 8'h01 && p <= 8'h05) || (p >= 8'h40 && p <= 8'h5f))
    begin
      return p + 8'h01;
    end
    return (p == 8'h06) ? 8'h00 : p;
  endfunction : nextPtr

  // raw length of the current low phase of the bus clock
  always_ff @(posedge clk_sys)
  begin
    lowCnt_ff <= (rst || scl) ? '0 : lowCnt_ff + 32'h1;
    if (rdStrobe)
    begin
      strobeAddr_ff <= rdAddr;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_irq_follows; port_event_irq_n != timeoutFlag; endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq not flag");
  property p_open_drain; sdaOut == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven high");
  property p_sda_steady; scl && $past(scl, 2) |-> $stable(sdaOe); endproperty
  a_sda_steady: assert property (p_sda_steady) else $error("sda moved, clock high");
  property p_tout_window;
    $rose(timeoutFlag) |-> lowCnt_ff >= TOUT_CYCLES && lowCnt_ff <= TOUT_CYCLES + 8;
  endproperty
  a_tout_window: assert property (p_tout_window) else $error("timeout length");
  property p_tout_enabled; $rose(timeoutFlag) |-> $past(timeoutEn); endproperty
  a_tout_enabled: assert property (p_tout_enabled) else $error("timeout disabled");
  property p_tout_release; $rose(timeoutFlag) |-> !sdaOe; endproperty
  a_tout_release: assert property (p_tout_release) else $error("sda held");
  property p_flag_sticky; timeoutFlag && !flagRdClr |=> timeoutFlag; endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
  property p_flag_clear; scl [*4] ##0 flagRdClr |=> !timeoutFlag; endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
  property p_buffer_hold; wrValid && !wrReady |=> wrValid && $stable(wrData); endproperty
  a_buffer_hold: assert property (p_buffer_hold) else $error("buffer word lost");
  property p_read_step; rdStrobe |-> ##[40:90] rdAddr == nextPtr(strobeAddr_ff); endproperty
  a_read_step: assert property (p_read_step) else $error("read pointer step");

  c_timeout: cover property ($rose(timeoutFlag));
  c_read: cover property (rdStrobe);
  c_pop: cover property (wrValid && wrReady);
endmodule : kip_slave_port_monitor
`default_nettype wire

// ### bench/kip_master_model.sv
// behavioural two-wire bus master
`timescale 1ns/1ps
`default_nettype none

module kip_master_model (
  input wire logic clk_sys,
  input wire logic sdaWire,
  output var logic scl,
  output var logic sdaPull
);
  // ---
  // bus cycles, 8 system clocks per bit
  // ---
  initial
  begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end

  task automatic waitLow(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : waitLow

  task automatic clkBit(input logic b, output logic r);
    waitLow(2);
    sdaPull = !b;
    waitLow(2);
    scl = 1'b1;
    waitLow(2);
    r = sdaWire;
    waitLow(2);
    scl = 1'b0;
  endtask : clkBit

  task automatic start();
    waitLow(2);
    sdaPull = 1'b0;
    waitLow(2);
    scl = 1'b1;
    waitLow(4);
    sdaPull = 1'b1;
    waitLow(4);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    waitLow(2);
    sdaPull = 1'b1;
    waitLow(2);
    scl = 1'b1;
    waitLow(4);
    sdaPull = 1'b0;
    waitLow(4);
  endtask : stop

  task automatic sendBits(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      clkBit(d[i], r);
    end
  endtask : sendBits

  task automatic writeByte(input logic [7:0] d, output logic ack);
    logic r;
    sendBits(d);
    clkBit(1'b1, r);
    ack = !r;
  endtask : writeByte

  task automatic readByte(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 0; i < 8; i++)
    begin
      clkBit(1'b1, r);
      d = {d[6:0], r};
    end
    clkBit(last, r);
  endtask : readByte
endmodule : kip_master_model
`default_nettype wire

// ### bench/kip_slave_port_test.sv
// self-checking bench of the two-wire slave port
`timescale 1ns/1ps
`default_nettype none

module kip_slave_port_test;
  // ---
  // bench, device and bus
  // ---
  localparam int TOUT = 200;
  logic clk_sys, rst, timeoutEn, flagRdClr, wrReady, sdaWire, strapPin, sclLine, mstPull;
  logic sdaOut, sdaOe, timeoutFlag, port_event_irq_n, rdStrobe, wrValid, okAll;
  logic [1:0] strapSel;
  logic [2:0] lowBits;
  logic [7:0] rdAddr, rdData;
  kip_pkg::kip_wr_s wrData;
  kip_pkg::kip_wr_s got[$];
  int n_mismatch, compares;

  assign sdaWire = !(mstPull || sdaOe);
  assign strapPin = strapSel[1] ? (strapSel[0] ? sclLine : sdaWire) : strapSel[0];
  assign lowBits = {strapSel, 1'b0};
  assign rdData = rdAddr ^ 8'h3c;

  kip_slave_port #(.TOUT_CYCLES(TOUT)) dut (.clk_sys(clk_sys), .rst(rst), .scl(sclLine),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .address_strap_pin(strapPin),
    .timeoutEn(timeoutEn), .flagRdClr(flagRdClr), .timeoutFlag(timeoutFlag),
    .port_event_irq_n(port_event_irq_n), .rdAddr(rdAddr), .rdData(rdData),
    .rdStrobe(rdStrobe), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData));
  kip_master_model mst (.clk_sys(clk_sys), .sdaWire(sdaWire), .scl(sclLine), .sdaPull(mstPull));

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    if (!rst && wrValid === 1'b1 && wrReady === 1'b1)
    begin
      got.push_back(wrData);
    end
  end

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic summarize();
    if (n_mismatch == 0 && compares > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  function automatic logic [7:0] devAddr(input logic rw);
    return {4'h7, lowBits, rw};
  endfunction : devAddr

  task automatic wb(input logic [7:0] d);
    logic a;
    mst.writeByte(d, a);
    okAll &= a;
  endtask : wb

  // ---
  // scenarios
  // ---
  task automatic t_address();
    logic ack;
    for (int s = 0; s < 4; s++)
    begin
      strapSel = s[1:0];
      mst.start();
      mst.writeByte(devAddr(1'b0), ack);
      mst.stop();
      chk(ack === 1'b1, "own address not acknowledged");
      mst.start();
      mst.writeByte({4'h7, lowBits ^ 3'h2, 1'b0}, ack);
      mst.stop();
      chk(ack === 1'b0, "foreign address acknowledged");
    end
  endtask : t_address

  task automatic t_write();
    logic [7:0] exA [3] = '{8'h05, 8'h06, 8'h00};
    logic [7:0] dat [3] = '{8'ha1, 8'hb2, 8'hc3};
    okAll = 1'b1;
    got.delete();
    mst.start();
    wb(devAddr(1'b0));
    wb(8'h05);
    for (int i = 0; i < 3; i++)
    begin
      wb(dat[i]);
    end
    mst.stop();
    chk(okAll === 1'b1 && got.size() == 3, "write bytes");
    for (int i = 0; i < 3 && i < got.size(); i++)
    begin
      chk(got[i] === {exA[i], dat[i]}, "write target");
    end
    chk(rdAddr === 8'h00, "pointer after wrap");
  endtask : t_write

  task automatic t_cmd_only();
    okAll = 1'b1;
    got.delete();
    mst.start();
    wb(devAddr(1'b0));
    wb(8'h5e);
    mst.stop();
    chk(okAll === 1'b1 && rdAddr === 8'h5e && got.size() == 0, "command only");
  endtask : t_cmd_only

  task automatic t_read();
    logic [7:0] d0, d1;
    okAll = 1'b1;
    mst.start();
    wb(devAddr(1'b1));
    mst.readByte(d0, 1'b0);
    mst.readByte(d1, 1'b1);
    mst.stop();
    chk(d0 === (8'h5e ^ 8'h3c) && d1 === (8'h5f ^ 8'h3c), "read data");
    chk(rdAddr === 8'h60, "read pointer");
    mst.start();
    wb(devAddr(1'b0));
    wb(8'h04);
    mst.start();
    wb(devAddr(1'b1));
    mst.readByte(d0, 1'b1);
    mst.stop();
    chk(okAll === 1'b1 && d0 === (8'h04 ^ 8'h3c) && rdAddr === 8'h05, "reread");
  endtask : t_read

  task automatic t_fill();
    logic ack;
    int n;
    okAll = 1'b1;
    got.delete();
    wrReady = 1'b0;
    mst.start();
    wb(devAddr(1'b0));
    wb(8'h00);
    for (int i = 0; i < 32; i++)
    begin
      wb(i[7:0]);
    end
    mst.writeByte(8'h20, ack);
    mst.stop();
    chk(okAll === 1'b1 && ack === 1'b0, "full buffer not refused");
    chk(wrValid === 1'b1 && got.size() == 0, "stalled buffer");
    wrReady = 1'b1;
    for (n = 0; n < 100 && wrValid !== 1'b0; n++)
    begin
      @(negedge clk_sys);
    end
    chk(n < 100 && got.size() == 32, "drain");
    for (int i = 0; i < 32 && i < got.size(); i++)
    begin
      chk(got[i] === {8'h00, i[7:0]}, "held pointer target");
    end
  endtask : t_fill

  task automatic t_timeout();
    logic ack;
    okAll = 1'b1;
    mst.start();
    wb(devAddr(1'b0));
    mst.sendBits(8'h11);
    mst.waitLow(10);
    chk(sdaOe === 1'b1, "no acknowledge drive");
    mst.waitLow(TOUT + 20);
    chk(timeoutFlag === 1'b1 && port_event_irq_n === 1'b0 && sdaOe === 1'b0, "abort");
    mst.writeByte(devAddr(1'b0), ack);
    mst.stop();
    chk(ack === 1'b0 && timeoutFlag === 1'b1, "answered without start");
    flagRdClr = 1'b1;
    @(negedge clk_sys);
    flagRdClr = 1'b0;
    chk(timeoutFlag === 1'b0 && port_event_irq_n === 1'b1, "flag clear");
    timeoutEn = 1'b0;
    mst.start();
    wb(devAddr(1'b0));
    mst.sendBits(8'h11);
    mst.waitLow(TOUT + 60);
    chk(timeoutFlag === 1'b0 && sdaOe === 1'b1, "timeout while disabled");
    mst.clkBit(1'b1, ack);
    mst.stop();
    timeoutEn = 1'b1;
    mst.start();
    wb(devAddr(1'b0));
    mst.waitLow(150);
    mst.clkBit(1'b0, ack);
    mst.waitLow(150);
    mst.stop();
    chk(okAll === 1'b1 && timeoutFlag === 1'b0, "split low phases");
  endtask : t_timeout

  initial
  begin
    rst = 1'b1;
    timeoutEn = 1'b1;
    flagRdClr = 1'b0;
    wrReady = 1'b1;
    strapSel = 2'h0;
    okAll = 1'b1;
    n_mismatch = 0;
    compares = 0;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    t_address();
    t_write();
    t_cmd_only();
    t_read();
    t_fill();
    t_timeout();
    summarize();
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    $display("[FAIL] %0t run limit reached", $time);
    summarize();
  end
endmodule : kip_slave_port_test

bind kip_slave_port kip_slave_port_monitor #(.TOUT_CYCLES(TOUT_CYCLES)) u_mon (
  .clk_sys(clk_sys), .rst(rst), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .address_strap_pin(address_strap_pin), .timeoutEn(timeoutEn), .flagRdClr(flagRdClr),
  .timeoutFlag(timeoutFlag), .port_event_irq_n(port_event_irq_n), .rdAddr(rdAddr),
  .rdData(rdData), .rdStrobe(rdStrobe), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData));
`default_nettype wire
